// >>> rtl/ddc_control.sv
// Control-command logic of a dual converter behind a two-wire serial link
`timescale 1ns/1ps
`include "ddc_cfg.svh"

module ddc_control (
    input  wire logic              i_ref_clk,
    input  wire logic              i_arst_n,
    input  wire logic              i_scl,
    input  wire logic              i_sda,
    output logic                   o_sda,
    output logic                   o_sda_oe,
    input  wire logic              i_load_strobe_n,
    input  wire logic              i_async_clear_n,
    output logic                   o_async_clear_n,
    output logic                   o_async_clear_oe,
    output logic [15:0]            o_dac_a,
    output logic [15:0]            o_dac_b,
    output ddc_pkg::ddc_pmode_e    o_power_mode_a,
    output ddc_pkg::ddc_pmode_e    o_power_mode_b,
    output logic                   o_ref_enable,
    output logic                   o_clear_mode,
    output logic                   o_hs_mode
);

    // ==========================================================
    // Declarations
    logic [1:0]          scl_s;
    logic [1:0]          sda_s;
    logic [1:0]          ld_s;
    logic [1:0]          clr_s;
    logic                scl_d;
    logic                sda_d;
    logic                ld_d;
    logic                clr_d;
    logic                scl_rise;
    logic                scl_fall;
    logic                start_seen;
    logic                stop_seen;
    logic                ld_fall;
    logic                clr_fall;
    logic                strobe_ok;
    logic [4:0]          por_cnt;
    logic                por_busy;
    logic [9:0]          rst_cnt;
    logic                rst_busy;
    ddc_pkg::ddc_link_e  state;
    logic [2:0]          bit_cnt;
    logic [1:0]          byte_idx;
    logic [7:0]          shreg;
    logic [7:0]          next_byte;
    logic [23:0]         frame;
    logic                ack_want;
    logic                ack_oe;
    logic                hs_mode;
    logic                frame_done;
    logic [2:0]          cmd;
    logic [2:0]          adr;
    logic [15:0]         data;
    logic                sw_rst;
    logic                full_rst;
    logic                is_write;
    logic [1:0]          mask;
    logic [15:0]         in_reg [2];
    logic [15:0]         dac_reg [2];
    ddc_pkg::ddc_pmode_e pmode [2];
    logic                ref_en;
    logic                clear_mode;

    // Channel decode from the address field, used for both channels
    function automatic logic chan_sel(input logic [2:0] a, input logic ch);
        chan_sel = (a == `DDC_ADR_ALL) || (a == (ch ? `DDC_ADR_B : `DDC_ADR_A));
    endfunction

    // ==========================================================
    // Input synchronisers
    // Pins come from outside this clock; second stage feeds all logic
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            scl_s <= 2'h3;
            sda_s <= 2'h3;
            ld_s  <= 2'h3;
            clr_s <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            ld_d  <= 1'b1;
            clr_d <= 1'b1;
        end else begin
            scl_s <= {scl_s[0], i_scl};
            sda_s <= {sda_s[0], i_sda};
            ld_s  <= {ld_s[0], i_load_strobe_n};
            clr_s <= {clr_s[0], i_async_clear_n};
            scl_d <= scl_s[1];
            sda_d <= sda_s[1];
            ld_d  <= ld_s[1];
            clr_d <= clr_s[1];
        end
    end

    // Edge and bus condition detection
    assign scl_rise   = scl_s[1] & ~scl_d;
    assign scl_fall   = ~scl_s[1] & scl_d;
    assign start_seen = scl_s[1] & scl_d & sda_d & ~sda_s[1];
    assign stop_seen  = scl_s[1] & scl_d & ~sda_d & sda_s[1];
    assign ld_fall    = ld_d & ~ld_s[1];
    // Own reset pulse on the clear line must not re-trigger a clear
    assign clr_fall   = clr_d & ~clr_s[1] & ~por_busy & ~rst_busy;
    // Strobe only honoured outside power-on and with clear released
    assign strobe_ok  = ~por_busy & clr_s[1];

    // ==========================================================
    // Power-on hold and full reset pulse
    // Power-on hold window
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            por_cnt <= 5'h00;
        end else if (por_busy) begin
            por_cnt <= por_cnt + 5'h01;
        end
    end
    assign por_busy = (por_cnt != `DDC_POR_CYC);

    // Clear line held low while a full reset completes
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_cnt <= 10'h000;
        end else if (full_rst) begin
            rst_cnt <= 10'(`DDC_RST_PULSE_CYC);
        end else if (rst_busy) begin
            rst_cnt <= rst_cnt - 10'h001;
        end
    end
    assign rst_busy         = (rst_cnt != 10'h000);
    assign o_async_clear_n  = 1'b0;
    assign o_async_clear_oe = rst_busy;

    // ==========================================================
    // Serial receiver
    assign next_byte = {shreg[6:0], sda_s[1]};

    // Receiver state, byte assembly and acknowledge
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state      <= ddc_pkg::LS_IDLE;
            bit_cnt    <= 3'h0;
            byte_idx   <= 2'h0;
            shreg      <= 8'h00;
            frame      <= 24'h000000;
            ack_want   <= 1'b0;
            ack_oe     <= 1'b0;
            frame_done <= 1'b0;
        end else begin
            frame_done <= 1'b0;
            if (sw_rst) begin
                frame <= 24'h000000;
            end
            if (clr_fall && state != ddc_pkg::LS_IDLE) begin
                state  <= ddc_pkg::LS_SKIP;
                ack_oe <= 1'b0;
            end else if (start_seen) begin
                // A start during power-on or full reset is dropped
                state    <= (rst_busy || por_busy) ? ddc_pkg::LS_SKIP
                                                   : ddc_pkg::LS_RECV;
                bit_cnt  <= 3'h0;
                byte_idx <= 2'h0;
                ack_oe   <= 1'b0;
            end else if (stop_seen) begin
                state  <= ddc_pkg::LS_IDLE;
                ack_oe <= 1'b0;
            end else begin
                unique case (state)
                    ddc_pkg::LS_IDLE, ddc_pkg::LS_SKIP: begin
                        ack_oe <= 1'b0;
                    end
                    ddc_pkg::LS_RECV: begin
                        if (scl_rise) begin
                            shreg   <= next_byte;
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == 3'h7) begin
                                state <= ddc_pkg::LS_ACK;
                                if (byte_idx == 2'h0) begin
                                    // Only a write to our address is taken
                                    ack_want <= (next_byte == {`DDC_DEV_ADDR, 1'b0});
                                end else begin
                                    ack_want <= 1'b1;
                                    frame    <= {frame[15:0], next_byte};
                                end
                            end
                        end
                    end
                    ddc_pkg::LS_ACK: begin
                        if (scl_fall) begin
                            if (!ack_oe) begin
                                ack_oe <= ack_want;
                                if (!ack_want) begin
                                    state <= ddc_pkg::LS_SKIP;
                                end
                            end else begin
                                // Ninth clock fall
                                ack_oe <= 1'b0;
                                state  <= ddc_pkg::LS_RECV;
                                if (byte_idx == 2'h3) begin
                                    frame_done <= 1'b1;
                                    byte_idx   <= 2'h1;
                                end else begin
                                    byte_idx <= byte_idx + 2'h1;
                                end
                            end
                        end
                    end
                endcase
            end
        end
    end
    assign o_sda    = 1'b0;
    assign o_sda_oe = ack_oe;

    // High speed mode follows the master code, left on stop or clear
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hs_mode <= 1'b0;
        end else if (clr_fall || stop_seen || full_rst) begin
            hs_mode <= 1'b0;
        end else if (state == ddc_pkg::LS_RECV && scl_rise && bit_cnt == 3'h7
                     && byte_idx == 2'h0
                     && next_byte[7:3] == `DDC_HS_PREFIX) begin
            hs_mode <= 1'b1;
        end
    end
    assign o_hs_mode = hs_mode;

    // ==========================================================
    // Command decode
    assign cmd      = frame[`DDC_CMD_HI:`DDC_CMD_LO];
    assign adr      = frame[`DDC_ADR_HI:`DDC_ADR_LO];
    assign data     = frame[15:0];
    assign sw_rst   = frame_done && cmd == `DDC_CMD_RESET;
    assign full_rst = sw_rst && frame[0];
    assign is_write = frame_done && (cmd == `DDC_CMD_WR_IN
                      || cmd == `DDC_CMD_WR_UPD_ALL || cmd == `DDC_CMD_WR_UPD);

    // ==========================================================
    // Input and DAC registers, one pair per channel
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (int ch = 0; ch < 2; ch++) begin
                in_reg[ch]  <= 16'h0000;
                dac_reg[ch] <= 16'h0000;
            end
        end else begin
            for (int ch = 0; ch < 2; ch++) begin
                logic        wr;
                logic        upd;
                logic [15:0] nxt;
                wr  = is_write && chan_sel(adr, ch[0]);
                nxt = wr ? data : in_reg[ch];
                upd = (wr && mask[ch])
                      || (frame_done && cmd == `DDC_CMD_WR_UPD_ALL)
                      || (wr && cmd == `DDC_CMD_WR_UPD)
                      || (frame_done && cmd == `DDC_CMD_UPDATE
                          && chan_sel(adr, ch[0]))
                      || (!mask[ch] && strobe_ok
                          && (ld_fall || (!ld_s[1] && wr)));
                if (clr_fall || sw_rst) begin
                    in_reg[ch]  <= 16'h0000;
                    dac_reg[ch] <= 16'h0000;
                end else begin
                    in_reg[ch] <= nxt;
                    if (upd) begin
                        dac_reg[ch] <= nxt;
                    end
                end
            end
        end
    end
    assign o_dac_a = dac_reg[0];
    assign o_dac_b = dac_reg[1];

    // ==========================================================
    // Configuration registers
    // Load mask; full reset returns it to pin control
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mask <= `DDC_MASK_RST;
        end else if (full_rst) begin
            mask <= `DDC_MASK_RST;
        end else if (frame_done && cmd == `DDC_CMD_LDMASK) begin
            mask <= frame[1:0];
        end
    end

    // Power modes; they never touch the DAC registers
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pmode[0] <= ddc_pkg::PM_NORMAL;
            pmode[1] <= ddc_pkg::PM_NORMAL;
        end else if (full_rst) begin
            pmode[0] <= ddc_pkg::PM_NORMAL;
            pmode[1] <= ddc_pkg::PM_NORMAL;
        end else if (frame_done && cmd == `DDC_CMD_POWER) begin
            if (frame[`DDC_SEL_A]) begin
                pmode[0] <= ddc_pkg::ddc_pmode_e'(frame[`DDC_PM_HI:`DDC_PM_LO]);
            end
            if (frame[`DDC_SEL_B]) begin
                pmode[1] <= ddc_pkg::ddc_pmode_e'(frame[`DDC_PM_HI:`DDC_PM_LO]);
            end
        end
    end
    assign o_power_mode_a = pmode[0];
    assign o_power_mode_b = pmode[1];

    // Internal reference enable, off after power-up
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ref_en <= 1'b0;
        end else if (full_rst) begin
            ref_en <= 1'b0;
        end else if (frame_done && cmd == `DDC_CMD_REFSET) begin
            ref_en <= frame[0];
        end
    end
    assign o_ref_enable = ref_en;

    // Cleared state; a new clear edge wins over a completing write
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            clear_mode <= 1'b0;
        end else if (clr_fall) begin
            clear_mode <= 1'b1;
        end else if (frame_done) begin
            clear_mode <= 1'b0;
        end
    end
    assign o_clear_mode = clear_mode;

endmodule // ddc_control

// >>> rtl/ddc_cfg.svh
// Constants for the dual converter control-command block
`ifndef DDC_CFG_SVH
`define DDC_CFG_SVH

// ==========================================================
// Command codes
`define DDC_CMD_WR_IN       3'h0
`define DDC_CMD_UPDATE      3'h1
`define DDC_CMD_WR_UPD_ALL  3'h2
`define DDC_CMD_WR_UPD      3'h3
`define DDC_CMD_POWER       3'h4
`define DDC_CMD_RESET       3'h5
`define DDC_CMD_LDMASK      3'h6
`define DDC_CMD_REFSET      3'h7

// ==========================================================
// Frame fields
`define DDC_CMD_HI          21
`define DDC_CMD_LO          19
`define DDC_ADR_HI          18
`define DDC_ADR_LO          16
`define DDC_PM_HI           5
`define DDC_PM_LO           4
`define DDC_SEL_B           1
`define DDC_SEL_A           0
`define DDC_ADR_A           3'h0
`define DDC_ADR_B           3'h1
`define DDC_ADR_ALL         3'h7

// ==========================================================
// Link addressing (device address value is arbitrary)
`define DDC_DEV_ADDR        7'h0C
`define DDC_HS_PREFIX       5'h01

// ==========================================================
// Reset values and timing
`define DDC_MASK_RST        2'h0
`define DDC_CLK_PERIOD_NS   5
`define DDC_RST_PULSE_NS    5000
`define DDC_RST_PULSE_CYC   (`DDC_RST_PULSE_NS / `DDC_CLK_PERIOD_NS)
`define DDC_POR_CYC         5'h10

`endif

// >>> rtl/ddc_pkg.sv
// Types shared by the dual converter control-command block
package ddc_pkg;

    // Serial link receiver states
    typedef enum logic [1:0] {
        LS_IDLE = 2'b00,
        LS_RECV = 2'b01,
        LS_ACK  = 2'b10,
        LS_SKIP = 2'b11
    } ddc_link_e;

    // Output stage modes
    typedef enum logic [1:0] {
        PM_NORMAL  = 2'b00,
        PM_PD_1K   = 2'b01,
        PM_PD_100K = 2'b10,
        PM_HIZ     = 2'b11
    } ddc_pmode_e;

endpackage

// >>> tb/ddc_control_chk.sv
// Pin-level checks of the dual converter control-command block
`timescale 1ns/1ps

module ddc_control_chk (
    input  wire logic                i_ref_clk,
    input  wire logic                i_arst_n,
    input  wire logic                i_async_clear_n,
    input  wire logic                o_sda_oe,
    input  wire logic                o_async_clear_oe,
    input  wire logic [15:0]         o_dac_a,
    input  wire logic [15:0]         o_dac_b,
    input  wire ddc_pkg::ddc_pmode_e o_power_mode_a,
    input  wire ddc_pkg::ddc_pmode_e o_power_mode_b,
    input  wire logic                o_ref_enable,
    input  wire logic                o_clear_mode,
    input  wire logic                o_hs_mode
);
    logic [5:0]  por_cnt;
    logic [10:0] pulse_cnt;

    // ==========================================================
    // Helpers: cycles since reset release, length of own clear pulse
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            por_cnt <= 6'h00;
        end else if (por_cnt != 6'h3F) begin
            por_cnt <= por_cnt + 6'h01;
        end
    end

    // Counter restarts whenever the line is released
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pulse_cnt <= 11'h000;
        end else if (o_async_clear_oe) begin
            pulse_cnt <= pulse_cnt + 11'h001;
        end else begin
            pulse_cnt <= 11'h000;
        end
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);

    // Own pulse excluded: the device pulling the line must not clear itself
    sequence s_clr_edge;
        $fell(i_async_clear_n) && (por_cnt >= 6'h14) && !o_async_clear_oe;
    endsequence

    sequence s_ack;
        o_sda_oe [*8] ##[1:40] !o_sda_oe;
    endsequence

    a_por_quiet: assert property ((por_cnt < 6'h10) |->
        (o_dac_a == 16'h0000 && o_dac_b == 16'h0000 && !o_ref_enable))
        else $error("outputs moved during power-on hold");
    a_pulse_len: assert property ($fell(o_async_clear_oe) |->
        (pulse_cnt >= 11'h3E7 && pulse_cnt <= 11'h3E9))
        else $error("full reset pulse has wrong length");
    a_pulse_quiet: assert property ((o_async_clear_oe && $past(o_async_clear_oe, 8)) |->
        !o_sda_oe)
        else $error("transfer acknowledged during reset pulse");
    a_reset_zero: assert property ($rose(o_async_clear_oe) |-> ##[0:4]
        (o_dac_a == 16'h0000 && o_power_mode_a == ddc_pkg::PM_NORMAL && !o_ref_enable))
        else $error("full reset left state behind");
    a_clear_zero: assert property (s_clr_edge |-> ##[2:6]
        (o_dac_a == 16'h0000 && o_dac_b == 16'h0000 && o_clear_mode))
        else $error("clear edge did not zero the outputs");
    a_hs_exit: assert property (s_clr_edge |-> ##[1:6] !o_hs_mode)
        else $error("clear edge left high speed mode on");
    a_dac_hold: assert property (($changed(o_power_mode_a) &&
        o_power_mode_a != ddc_pkg::PM_NORMAL) |-> $stable(o_dac_a))
        else $error("power mode change altered the dac value");
    a_ack_shape: assert property ($rose(o_sda_oe) |-> s_ack)
        else $error("acknowledge pulse has wrong length");
endmodule // ddc_control_chk

bind ddc_control ddc_control_chk u_chk (.i_ref_clk, .i_arst_n, .i_async_clear_n, .o_sda_oe,
    .o_async_clear_oe, .o_dac_a, .o_dac_b, .o_power_mode_a, .o_power_mode_b, .o_ref_enable,
    .o_clear_mode, .o_hs_mode);

// >>> tb/ddc_host.sv
// Bus controller model that sends write frames to the converter block
`timescale 1ns/1ps
`include "ddc_cfg.svh"

module ddc_host (
    input  wire logic i_clk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda
);
    // ==========================================================
    // Lines idle released; 1 lets the board pull-up win
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    // Lines only move just after a falling reference edge
    task automatic hold(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    // One bit of 25 reference cycles (125 ns); data moves while clock low
    task automatic clk_bit(input logic b, output logic seen);
        o_sda = b;
        hold(6);
        o_scl = 1'b1;
        hold(6);
        seen = i_sda;
        hold(6);
        o_scl = 1'b0;
        hold(7);
    endtask

    // Start and stop move data while the clock is high
    task automatic start_c();
        o_scl = 1'b1;
        hold(12);
        o_sda = 1'b0;
        hold(12);
        o_scl = 1'b0;
        hold(6);
    endtask

    task automatic stop_c();
        o_sda = 1'b0;
        hold(6);
        o_scl = 1'b1;
        hold(12);
        o_sda = 1'b1;
        hold(12);
    endtask

    // Eight bits, most significant first, then a released ninth bit
    task automatic put_byte(input logic [7:0] b, output logic acked);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], s);
        end
        clk_bit(1'b1, s);
        acked = ~s;
    endtask

    // Address byte, command byte, data high and low; counts acknowledges
    task automatic frame(input logic [7:0] c, input logic [15:0] d, output logic [15:0] acks);
        logic       a;
        logic [7:0] q [4];
        q = '{{`DDC_DEV_ADDR, 1'b0}, c, d[15:8], d[7:0]};
        acks = 16'h0000;
        start_c();
        for (int i = 0; i < 4; i++) begin
            put_byte(q[i], a);
            acks = acks + {15'h0000, a};
        end
        stop_c();
    endtask
endmodule // ddc_host

// >>> tb/tb.sv
// Self-checking bench for the dual converter control-command block
`timescale 1ns/1ps
`include "ddc_cfg.svh"

module tb;
    logic                clk;
    logic                rst_n;
    logic                strobe_n;
    logic                clr_drv_n;
    logic                scl;
    logic                host_sda;
    logic                ack;
    logic [15:0]         acks;
    logic                sda_oe;
    logic                clr_oe;
    logic [15:0]         dac_a;
    logic [15:0]         dac_b;
    ddc_pkg::ddc_pmode_e pm_a;
    ddc_pkg::ddc_pmode_e pm_b;
    logic                ref_en;
    logic                clr_mode;
    logic                hs;
    logic                sda_lvl;
    logic                clr_lvl;
    int                  errors;
    int                  cmp_count;
    int                  cycles;
    wire                 sda_line;
    wire                 clr_line;

    // Open-drain lines with pull-ups: the device pulls only its driven level
    assign sda_line = host_sda & (sda_lvl | ~sda_oe);
    assign clr_line = clr_drv_n & (clr_lvl | ~clr_oe);

    ddc_control DUT (.i_ref_clk(clk), .i_arst_n(rst_n), .i_scl(scl), .i_sda(sda_line),
        .o_sda(sda_lvl), .o_sda_oe(sda_oe), .i_load_strobe_n(strobe_n),
        .i_async_clear_n(clr_line), .o_async_clear_n(clr_lvl), .o_async_clear_oe(clr_oe),
        .o_dac_a(dac_a), .o_dac_b(dac_b),
        .o_power_mode_a(pm_a), .o_power_mode_b(pm_b), .o_ref_enable(ref_en),
        .o_clear_mode(clr_mode), .o_hs_mode(hs));

    ddc_host host (.i_clk(clk), .i_sda(sda_line), .o_scl(scl), .o_sda(host_sda));

    // ==========================================================
    // Clock and hang guard; the run needs about 26500 cycles
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            test_done();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Reserved leading bit is always sent as 0 in every command byte
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        host.frame(c, d, acks);
        wait_clk(4);
    endtask

    task automatic strobe();
        strobe_n = 1'b0;
        wait_clk(6);
        strobe_n = 1'b1;
        wait_clk(6);
    endtask

    task automatic test_done();
        if (errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_load();
        check("dac a reset", dac_a, 16'h0000);
        check("ref reset", {15'h0000, ref_en}, 16'h0000);
        wr(8'h00, 16'h1234);
        check("acks", acks, 16'h0004);
        check("dac a held", dac_a, 16'h0000);
        strobe();
        check("dac a strobed", dac_a, 16'h1234);
        wr(8'h30, 16'h0001);
        wr(8'h00, 16'hBEEF);
        check("dac a direct", dac_a, 16'hBEEF);
        wr(8'h01, 16'h4321);
        check("dac b held", dac_b, 16'h0000);
        strobe_n = 1'b0;
        wr(8'h01, 16'h7777);
        check("dac b strobe low", dac_b, 16'h7777);
        strobe_n = 1'b1;
    endtask

    task automatic t_power();
        for (int m = 0; m < 4; m++) begin
            wr(8'h20, {10'h000, m[1:0], 4'h1});
            check("pm a", {14'h0000, pm_a}, {14'h0000, m[1:0]});
            check("pm b kept", {14'h0000, pm_b}, 16'h0000);
        end
        wr(8'h20, 16'h0022);
        check("pm b", {14'h0000, pm_b}, 16'h0002);
        check("pm a kept", {14'h0000, pm_a}, 16'h0003);
        check("dac a kept", dac_a, 16'hBEEF);
        wr(8'h38, 16'h0001);
        check("ref on", {15'h0000, ref_en}, 16'h0001);
        wr(8'h38, 16'hFFFE);
        check("ref off", {15'h0000, ref_en}, 16'h0000);
        wr(8'h38, 16'h0001);
    endtask

    task automatic t_reset();
        int n;
        wr(8'h11, 16'h5555);
        check("update all", dac_b, 16'h5555);
        wr(8'h19, 16'h6666);
        check("write update", dac_b, 16'h6666);
        wr(8'h01, 16'h7777);
        check("write held", dac_b, 16'h6666);
        wr(8'h09, 16'h0000);
        check("update cmd", dac_b, 16'h7777);
        wr(8'h28, 16'h0000);
        check("partial dac b", dac_b, 16'h0000);
        check("partial pm a", {14'h0000, pm_a}, 16'h0003);
        wr(8'h00, 16'h2222);
        check("partial mask kept", dac_a, 16'h2222);
        wr(8'h28, 16'h0001);
        check("pulse", {15'h0000, clr_oe}, 16'h0001);
        wr(8'h00, 16'h3333);
        check("ignored acks", acks, 16'h0000);
        n = 0;
        while (clr_oe === 1'b1 && n < 2000) begin
            wait_clk(1);
            n++;
        end
        check("pulse end", {15'h0000, clr_oe}, 16'h0000);
        check("full pm b", {14'h0000, pm_b}, 16'h0000);
        check("full ref", {15'h0000, ref_en}, 16'h0000);
        wr(8'h00, 16'h3333);
        check("full mask", dac_a, 16'h0000);
    endtask

    task automatic t_clear();
        wr(8'h30, 16'h0003);
        wr(8'h00, 16'h1111);
        host.start_c();
        host.put_byte(8'h08, ack);
        check("hs mode", {15'h0000, hs}, 16'h0001);
        clr_drv_n = 1'b0;
        wait_clk(8);
        check("clear dac a", dac_a, 16'h0000);
        check("hs exit", {15'h0000, hs}, 16'h0000);
        host.stop_c();
        clr_drv_n = 1'b1;
        host.start_c();
        host.put_byte({`DDC_DEV_ADDR, 1'b0}, ack);
        host.put_byte(8'h00, ack);
        host.put_byte(8'hAB, ack);
        clr_drv_n = 1'b0;
        wait_clk(8);
        host.put_byte(8'hCD, ack);
        host.stop_c();
        check("aborted", dac_a, 16'h0000);
        check("still cleared", {15'h0000, clr_mode}, 16'h0001);
        wr(8'h30, 16'h0000);
        check("clear exit", {15'h0000, clr_mode}, 16'h0000);
        wr(8'h01, 16'h0F0F);
        strobe();
        check("strobe ignored", dac_b, 16'h0000);
        clr_drv_n = 1'b1;
        wait_clk(6);
        strobe();
        check("strobe after", dac_b, 16'h0F0F);
    endtask

    // Main sequence: reset for 10 cycles, then the scenarios in turn
    initial begin
        rst_n = 1'b0;
        strobe_n = 1'b1;
        clr_drv_n = 1'b1;
        errors = 0;
        cmp_count = 0;
        cycles = 0;
        wait_clk(10);
        rst_n = 1'b1;
        wait_clk(30);
        t_load();
        t_power();
        t_reset();
        t_clear();
        test_done();
    end
endmodule // tb
